//--- shared/brd_pkg.sv
// Package for the motor run, fault-mask and diagnostic register group.
package brd_pkg;
	localparam logic [7:0] RUN_OFF = 8'h00;
	localparam logic [7:0] MASK_OFF = 8'h04;
	localparam logic [7:0] DIAGNOSTIC_OUTPUT_PIN_OFF = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
	localparam logic [11:0] RUN_RESET = 12'h200;
	localparam logic [11:0] MASK_RESET = 12'h000;
	localparam logic [15:0] DIAGNOSTIC_OUTPUT_PIN_RESET = 16'hC000;
	localparam int NFAULT = 12;
	localparam int GF_BIT = 15;
	localparam int POR_BIT = 14;
	localparam int UV_BIT = 13;
	localparam int LOS_BIT = 9;
	localparam logic [1:0] HYS_AUTO = 2'h0;
	localparam logic [1:0] HYS_NONE = 2'h1;
	localparam logic [1:0] HYS_HIGH = 2'h2;
	localparam logic [1:0] HYS_LOW = 2'h3;
	localparam logic [1:0] DG_FAULT_N = 2'h0;
	localparam logic [1:0] DG_LOS_N = 2'h1;
	localparam logic [1:0] DG_VDS = 2'h2;
	localparam logic [1:0] DG_CLK = 2'h3;
	localparam int WIN_BASE_NS = 400;
	localparam int CLK_NS = 8;
	localparam int WIN_BASE_CYC = (WIN_BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int IRQ_W = 3;
	typedef struct packed {
		logic [1:0] bemf_hysteresis_sel;
		logic [2:0] bemf_window_sel;
		logic stop_on_fail_en;
		logic [1:0] diagnostic_output_pin_pin_source_sel;
		logic restart_after_sync_loss_en;
		logic brake_enable;
		logic direction;
		logic run_enable;
	} brd_run_t;
	typedef struct packed {
		logic hyst_none;
		logic hyst_high;
		logic [12:0] window_cycles;
		logic brake;
		logic reverse;
		logic bridge_enable;
		logic restart_allowed;
	} brd_ctl_t;
endpackage : brd_pkg

//--- src/brd_regs.sv
// Run-control, fault-mask and diagnostic registers with an AHB-Lite slave.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
// Function
// - The hysteresis field picks auto (00, default), none (01), high (10) or low (11).
// - The window field picks 0.4us doubling per code up to 51.2us, default code 100.
// - With stop-on-fail set a detected fault stops the bridge, otherwise it is only reported.
// - The diagnostic_output_pin pin carries fault low-true, sync loss low-true, the Vds comparator or the clock.
// - Automatic restart after sync loss is allowed only when the restart bit is set.
// - The brake bit applies slow-decay braking, clear means normal drive.
// - Direction 0 steps commutation states 1 to 6, direction 1 steps 6 to 1.
// - Run enable starts the motor, clear disables all bridge outputs to coast.
// - The mask register has one bit for each of the twelve bridge and thermal faults.
// - A mask bit of 0 permits detection and 1 disables detection of its fault.
// - The diagnostic word carries general fault, power-on-reset and undervoltage flags.
// - After reset the diagnostic word reads with only the fault and reset flags set.
// - Temperature warning and thermal shutdown are separate diagnostic flags.
// - A dedicated diagnostic flag is set when back-EMF synchronisation is lost.
// - Each bootstrap capacitor and each high and low side switch has its own fault flag.
module brd_regs (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [11:0] fault_raw_i,
	input wire logic undervoltage_i,
	input wire logic drain_source_threshold_cmp_i,
	input wire logic [2:0] commutation_state_i,
	output brd_pkg::brd_ctl_t ctl_o,
	output logic [2:0] next_state_o,
	output logic diagnostic_output_pin_o,
	output logic irq_o
);
	brd_pkg::brd_run_t run_q;
	logic [11:0] mask_q;
	logic [15:0] diagnostic_output_pin_q;
	logic [brd_pkg::IRQ_W-1:0] irq_stat_q;
	logic [brd_pkg::IRQ_W-1:0] irq_mask_q;
	logic [11:0] f_s1_q, f_s2_q, f_s3_q;
	logic [1:0] u_s_q, v_s_q;
	logic u_s3_q, v_s3_q;
	logic [11:0] f_stable_q;
	logic uv_stable_q, vds_stable_q;
	logic stopped_q;
	logic ph_wr_q, ph_rd_q;
	logic [7:0] ph_addr_q;
	logic [31:0] rdata_q;
	logic [11:0] fault_det;
	logic any_fault;
	logic wr_run, wr_mask, wr_ist, wr_imsk, rd_diagnostic_output_pin;
	logic addr_ok;

	// Three-stage sampling; a change is accepted only when stages two and three agree.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			f_s1_q <= 12'h000;
			f_s2_q <= 12'h000;
			f_s3_q <= 12'h000;
			u_s_q <= 2'h0;
			v_s_q <= 2'h0;
			u_s3_q <= 1'b0;
			v_s3_q <= 1'b0;
			f_stable_q <= 12'h000;
			uv_stable_q <= 1'b0;
			vds_stable_q <= 1'b0;
		end else begin
			f_s1_q <= fault_raw_i;
			f_s2_q <= f_s1_q;
			f_s3_q <= f_s2_q;
			u_s_q <= {u_s_q[0], undervoltage_i};
			v_s_q <= {v_s_q[0], drain_source_threshold_cmp_i};
			u_s3_q <= u_s_q[1];
			v_s3_q <= v_s_q[1];
			for (int i = 0; i < brd_pkg::NFAULT; i++) begin
				if (f_s2_q[i] == f_s3_q[i]) begin
					f_stable_q[i] <= f_s3_q[i];
				end
			end
			if (u_s_q[1] == u_s3_q) begin
				uv_stable_q <= u_s3_q;
			end
			if (v_s_q[1] == v_s3_q) begin
				vds_stable_q <= v_s3_q;
			end
		end
	end

	// Bit 11 temp warning, 10 shutdown, 9 sync loss, 8..6 bootcaps, 5..0 Vds per switch.
	genvar g;
	generate
		for (g = 0; g < brd_pkg::NFAULT; g++) begin : g_det
			assign fault_det[g] = f_stable_q[g] & ~mask_q[g];
		end
	endgenerate
	assign any_fault = |fault_det;

	// Bus address phase capture; all answers take zero wait states.
	assign addr_ok = (ph_addr_q == brd_pkg::RUN_OFF) || (ph_addr_q == brd_pkg::MASK_OFF) ||
		(ph_addr_q == brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF) || (ph_addr_q == brd_pkg::IRQ_STAT_OFF) ||
		(ph_addr_q == brd_pkg::IRQ_MASK_OFF);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end else if (hready_i) begin
			ph_wr_q <= hsel_i & htrans_i[1] & hwrite_i;
			ph_rd_q <= hsel_i & htrans_i[1] & ~hwrite_i;
			ph_addr_q <= {haddr_i[7:2], 2'h0};
		end
	end
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign wr_run = ph_wr_q && ph_addr_q == brd_pkg::RUN_OFF;
	assign wr_mask = ph_wr_q && ph_addr_q == brd_pkg::MASK_OFF;
	assign wr_ist = ph_wr_q && ph_addr_q == brd_pkg::IRQ_STAT_OFF;
	assign wr_imsk = ph_wr_q && ph_addr_q == brd_pkg::IRQ_MASK_OFF;
	assign rd_diagnostic_output_pin = ph_rd_q && ph_addr_q == brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF;

	// Read data is registered in the address phase and holds until the next read transfer is accepted.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
			unique case ({haddr_i[7:2], 2'h0})
				brd_pkg::RUN_OFF: rdata_q <= {20'h00000, run_q};
				brd_pkg::MASK_OFF: rdata_q <= {20'h00000, mask_q};
				brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF: rdata_q <= {16'h0000, diagnostic_output_pin_q};
				brd_pkg::IRQ_STAT_OFF: rdata_q <= {29'h0000000, irq_stat_q};
				brd_pkg::IRQ_MASK_OFF: rdata_q <= {29'h0000000, irq_mask_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign hrdata_o = rdata_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_q <= brd_pkg::RUN_RESET;
		end else if (wr_run) begin
			run_q <= hwdata_i[11:0];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mask_q <= brd_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= hwdata_i[11:0];
		end
	end

	// Diagnostic flags latch until the word is read; a new detection in the read cycle wins.
	// Only the bits that the read returned are cleared, so a flag that was set after the
	// read data was captured is not lost before software has seen it.
	logic [15:0] diagnostic_output_pin_clr;
	assign diagnostic_output_pin_clr = rd_diagnostic_output_pin ? rdata_q[15:0] : 16'h0000;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			diagnostic_output_pin_q <= brd_pkg::DIAGNOSTIC_OUTPUT_PIN_RESET;
		end else begin
			diagnostic_output_pin_q[11:0] <= fault_det | (diagnostic_output_pin_q[11:0] & ~diagnostic_output_pin_clr[11:0]);
			diagnostic_output_pin_q[brd_pkg::GF_BIT] <= any_fault | uv_stable_q |
				(diagnostic_output_pin_q[brd_pkg::GF_BIT] & ~diagnostic_output_pin_clr[brd_pkg::GF_BIT]);
			diagnostic_output_pin_q[brd_pkg::POR_BIT] <= diagnostic_output_pin_q[brd_pkg::POR_BIT] &
				~diagnostic_output_pin_clr[brd_pkg::POR_BIT];
			diagnostic_output_pin_q[brd_pkg::UV_BIT] <= uv_stable_q |
				(diagnostic_output_pin_q[brd_pkg::UV_BIT] & ~diagnostic_output_pin_clr[brd_pkg::UV_BIT]);
			diagnostic_output_pin_q[12] <= 1'b0;
		end
	end

	// A stop holds until run enable is cleared, so a fault cannot be silently ridden through.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stopped_q <= 1'b0;
		end else if (!run_q.run_enable) begin
			stopped_q <= 1'b0;
		end else if (run_q.stop_on_fail_en && any_fault) begin
			stopped_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl_o <= '0;
		end else begin
			ctl_o.hyst_none <= run_q.bemf_hysteresis_sel == brd_pkg::HYS_NONE;
			ctl_o.hyst_high <= (run_q.bemf_hysteresis_sel == brd_pkg::HYS_HIGH) ||
				(run_q.bemf_hysteresis_sel == brd_pkg::HYS_AUTO && commutation_state_i == 3'h0);
			ctl_o.window_cycles <= 13'(brd_pkg::WIN_BASE_CYC) << run_q.bemf_window_sel;
			ctl_o.brake <= run_q.brake_enable;
			ctl_o.reverse <= run_q.direction;
			ctl_o.bridge_enable <= run_q.run_enable && !stopped_q &&
				!(run_q.stop_on_fail_en && any_fault);
			ctl_o.restart_allowed <= run_q.restart_after_sync_loss_en && run_q.run_enable;
		end
	end

	// Commutation successor; state 0 means not yet started and enters the sequence.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			next_state_o <= 3'h1;
		end else if (!run_q.direction) begin
			next_state_o <= (commutation_state_i >= 3'h6 || commutation_state_i == 3'h0) ? 3'h1 :
				commutation_state_i + 3'h1;
		end else begin
			next_state_o <= (commutation_state_i <= 3'h1 || commutation_state_i == 3'h7) ? 3'h6 :
				commutation_state_i - 3'h1;
		end
	end

	// The clock source is the divided enable toggling each cycle, not the raw clock net.
	logic clk_div_q;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clk_div_q <= 1'b0;
		end else begin
			clk_div_q <= ~clk_div_q;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			diagnostic_output_pin_o <= 1'b1;
		end else begin
			unique case (run_q.diagnostic_output_pin_pin_source_sel)
				brd_pkg::DG_FAULT_N: diagnostic_output_pin_o <= ~(any_fault | uv_stable_q);
				brd_pkg::DG_LOS_N: diagnostic_output_pin_o <= ~fault_det[brd_pkg::LOS_BIT];
				brd_pkg::DG_VDS: diagnostic_output_pin_o <= vds_stable_q;
				brd_pkg::DG_CLK: diagnostic_output_pin_o <= clk_div_q;
			endcase
		end
	end

	// Interrupt bits: 0 any unmasked fault, 1 sync loss, 2 undervoltage; set wins over clear.
	logic [brd_pkg::IRQ_W-1:0] irq_ev;
	assign irq_ev = {uv_stable_q, fault_det[brd_pkg::LOS_BIT], any_fault};
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
		end else begin
			irq_stat_q <= irq_ev | (irq_stat_q & ~(wr_ist ? hwdata_i[2:0] : 3'h0));
			if (wr_imsk) begin
				irq_mask_q <= hwdata_i[2:0];
			end
		end
	end
	assign irq_o = |(irq_stat_q & irq_mask_q);

	property p_masked_no_flag;
		@(posedge clk_i) disable iff (!arst_n_i)
		(mask_q[0] && f_stable_q[0] && rd_diagnostic_output_pin) |=> !diagnostic_output_pin_q[0];
	endproperty
	a_masked_no_flag: assert property (p_masked_no_flag) else $error("masked fault set flag");

	property p_fault_sets_flag;
		@(posedge clk_i) disable iff (!arst_n_i)
		fault_det[5] |=> diagnostic_output_pin_q[5] && diagnostic_output_pin_q[brd_pkg::GF_BIT];
	endproperty
	a_fault_sets_flag: assert property (p_fault_sets_flag) else $error("fault flag missing");

	property p_stop_on_fail;
		@(posedge clk_i) disable iff (!arst_n_i)
		(run_q.stop_on_fail_en && any_fault) |=> !ctl_o.bridge_enable;
	endproperty
	a_stop_on_fail: assert property (p_stop_on_fail) else $error("bridge not stopped");

	property p_report_only;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!run_q.stop_on_fail_en && run_q.run_enable && !stopped_q) |=> ctl_o.bridge_enable;
	endproperty
	a_report_only: assert property (p_report_only) else $error("bridge stopped");

	property p_run_off_coast;
		@(posedge clk_i) disable iff (!arst_n_i)
		!run_q.run_enable |=> !ctl_o.bridge_enable;
	endproperty
	a_run_off_coast: assert property (p_run_off_coast) else $error("bridge on without run");

	property p_window;
		@(posedge clk_i) disable iff (!arst_n_i)
		$stable(run_q.bemf_window_sel) |=>
			ctl_o.window_cycles == (13'd50 << $past(run_q.bemf_window_sel));
	endproperty
	a_window: assert property (p_window) else $error("window count wrong");

	property p_diagnostic_output_pin_fault_low;
		@(posedge clk_i) disable iff (!arst_n_i)
		(run_q.diagnostic_output_pin_pin_source_sel == 2'h0 && any_fault) |=> !diagnostic_output_pin_o;
	endproperty
	a_diagnostic_output_pin_fault_low: assert property (p_diagnostic_output_pin_fault_low) else $error("diagnostic_output_pin pin not low");

	property p_forward_step;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!run_q.direction && commutation_state_i == 3'h6) |=> next_state_o == 3'h1;
	endproperty
	a_forward_step: assert property (p_forward_step) else $error("forward wrap wrong");

	property p_reverse_step;
		@(posedge clk_i) disable iff (!arst_n_i)
		(run_q.direction && commutation_state_i == 3'h3) |=> next_state_o == 3'h2;
	endproperty
	a_reverse_step: assert property (p_reverse_step) else $error("reverse step wrong");

	property p_restart;
		@(posedge clk_i) disable iff (!arst_n_i)
		!run_q.restart_after_sync_loss_en |=> !ctl_o.restart_allowed;
	endproperty
	a_restart: assert property (p_restart) else $error("restart allowed");

	property p_brake_follow;
		@(posedge clk_i) disable iff (!arst_n_i)
		run_q.brake_enable |=> ctl_o.brake;
	endproperty
	a_brake_follow: assert property (p_brake_follow) else $error("brake not applied");

	property p_diagnostic_output_pin_vds;
		@(posedge clk_i) disable iff (!arst_n_i)
		(run_q.diagnostic_output_pin_pin_source_sel == brd_pkg::DG_VDS) |=>
			diagnostic_output_pin_o == $past(vds_stable_q);
	endproperty
	a_diagnostic_output_pin_vds: assert property (p_diagnostic_output_pin_vds) else $error("diagnostic_output_pin pin not comparator");

	property p_uv_flag;
		@(posedge clk_i) disable iff (!arst_n_i)
		uv_stable_q |=> diagnostic_output_pin_q[brd_pkg::UV_BIT] && diagnostic_output_pin_q[brd_pkg::GF_BIT];
	endproperty
	a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag missing");

	property p_los_flag;
		@(posedge clk_i) disable iff (!arst_n_i)
		fault_det[brd_pkg::LOS_BIT] |=> diagnostic_output_pin_q[brd_pkg::LOS_BIT];
	endproperty
	a_los_flag: assert property (p_los_flag) else $error("sync loss flag missing");
endmodule : brd_regs

//--- tb/bldc_run_mask_diagnostic_output_pin_regs_bench.sv
// Self-checking bench for the run, mask and diagnostic register group.
`timescale 1ns/1ns
module bldc_run_mask_diagnostic_output_pin_regs_bench;
	logic clk_i, arst_n_i, hsel, hwrite, uv, vds, dpin, irq, hrdy, hresp, stuck, p;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, cst, nxt;
	logic [31:0] hwdata, hrdata, q;
	logic [11:0] flt, r;
	brd_pkg::brd_ctl_t ctl;
	int n_fail, check_count, s, e, m_run, m_mask;
	brd_host host (.clk_i(clk_i), .hready_i(hrdy), .hrdata_i(hrdata), .hsel_o(hsel),
		.haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
		.hwdata_o(hwdata), .stuck_o(stuck));
	brd_regs uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
		.fault_raw_i(flt), .undervoltage_i(uv), .drain_source_threshold_cmp_i(vds),
		.commutation_state_i(cst), .ctl_o(ctl), .next_state_o(nxt),
		.diagnostic_output_pin_o(dpin), .irq_o(irq));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		check_count++;
		if (sn !== ex) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		if (a == brd_pkg::RUN_OFF) m_run = d & 32'hFFF;
		if (a == brd_pkg::MASK_OFF) m_mask = d & 32'hFFF;
		host.xfer(1'b1, a, d, q);
	endtask : wr
	task rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task close_out;
		if (stuck === 1'b1) n_fail++;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	initial begin
		arst_n_i = 1'b0;
		flt = 12'h000;
		uv = 1'b0;
		vds = 1'b0;
		cst = 3'h0;
		n_fail = 0;
		check_count = 0;
		m_run = 32'h200;
		m_mask = 32'h0;
		void'($urandom(32'h2201CC04));
		tick(4);
		arst_n_i <= 1'b1;
		tick(2);
		rd(brd_pkg::RUN_OFF);
		chk("run", 32'h200, q);
		rd(brd_pkg::MASK_OFF);
		chk("mask", 32'h0, q);
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin", 32'hC000, q);
		chk("window", 32'd800, ctl.window_cycles);
		chk("hyst high", 32'h1, ctl.hyst_high);
		$display("test reset values done");
		for (int i = 0; i < 16; i++) begin
			r = {i[1:0], i[2:0], 1'b0, 6'($urandom)};
			s = $urandom % 7;
			cst <= 3'(s);
			wr(brd_pkg::RUN_OFF, {20'h0, r});
			tick(2);
			rd(brd_pkg::RUN_OFF);
			chk("run rb", m_run, q);
			chk("hyst none", r[11:10] == 2'h1, ctl.hyst_none);
			chk("hyst high", r[11:10] == 2'h2 || (r[11:10] == 2'h0 && s == 0), ctl.hyst_high);
			chk("window", 32'd50 << r[9:7], ctl.window_cycles);
			chk("brake", r[2], ctl.brake);
			chk("reverse", r[1], ctl.reverse);
			chk("bridge", r[0], ctl.bridge_enable);
			chk("restart", r[3] && r[0], ctl.restart_allowed);
			e = r[1] ? (s <= 1 ? 6 : s - 1) : s % 6 + 1;
			chk("next", e, nxt);
		end
		$display("test run fields done");
		for (int k = 0; k < 4; k++) begin
			wr(brd_pkg::RUN_OFF, 32'h1 | (k << 4));
			vds <= 1'($urandom);
			tick(8);
			@(negedge clk_i);
			p = dpin;
			@(negedge clk_i);
			chk("pin", k == 3 ? !p : k == 2 ? vds : 1'b1, dpin);
		end
		$display("test diagnostic_output_pin pin done");
		wr(brd_pkg::RUN_OFF, 32'h1);
		for (int b = 0; b < 12; b++) begin
			flt <= 12'h1 << b;
			tick(8);
			chk("bridge", 32'h1, ctl.bridge_enable);
			chk("pin", 32'h0, dpin);
			e = 32'h8000 | (32'h1 << b);
			rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
			chk("diagnostic_output_pin", e, q);
			flt <= 12'h000;
			tick(8);
			rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
			chk("diagnostic_output_pin sticky", e, q);
		end
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin clear", 32'h0, q);
		$display("test fault flags done");
		rd(brd_pkg::IRQ_STAT_OFF);
		chk("irq stat", 32'h3, q);
		chk("irq", 32'h0, irq);
		wr(brd_pkg::IRQ_MASK_OFF, 32'h7);
		tick(1);
		chk("irq", 32'h1, irq);
		wr(brd_pkg::IRQ_STAT_OFF, 32'h1);
		tick(1);
		chk("irq", 32'h1, irq);
		wr(brd_pkg::IRQ_STAT_OFF, 32'h2);
		tick(1);
		chk("irq", 32'h0, irq);
		$display("test interrupt done");
		wr(brd_pkg::MASK_OFF, 32'hFFF);
		rd(brd_pkg::MASK_OFF);
		chk("mask rb", m_mask, q);
		wr(brd_pkg::RUN_OFF, 32'h41);
		flt <= 12'hFFF;
		tick(8);
		chk("bridge", 32'h1, ctl.bridge_enable);
		chk("irq", 32'h0, irq);
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin masked", 32'h0, q);
		wr(brd_pkg::MASK_OFF, 32'hFFE);
		tick(8);
		chk("bridge", 32'h0, ctl.bridge_enable);
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin unmask", 32'h8001, q);
		flt <= 12'h000;
		tick(8);
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin sticky", 32'h8001, q);
		$display("test mask and stop done");
		wr(brd_pkg::IRQ_STAT_OFF, 32'h7);
		tick(1);
		chk("irq", 32'h0, irq);
		uv <= 1'b1;
		tick(8);
		chk("irq", 32'h1, irq);
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin uv", 32'hA000, q);
		rd(brd_pkg::IRQ_STAT_OFF);
		chk("irq stat", 32'h4, q);
		wr(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20);
		chk("unmapped", 32'h0, q);
		chk("hresp", 32'h0, hresp);
		rd(brd_pkg::DIAGNOSTIC_OUTPUT_PIN_OFF);
		chk("diagnostic_output_pin ro", 32'hA000, q);
		$display("test access kinds done");
		close_out();
	end
endmodule : bldc_run_mask_diagnostic_output_pin_regs_bench

//--- tb/brd_host.sv
// AHB-Lite host model that issues single word transfers to the register group.
`timescale 1ns/1ns
module brd_host (
	input wire logic clk_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic hsel_o,
	output logic [7:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [2:0] hsize_o,
	output logic [31:0] hwdata_o,
	output logic stuck_o
);
	initial begin
		hsel_o = 1'b0;
		haddr_o = 8'h00;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = 3'h2;
		hwdata_o = 32'h0;
		stuck_o = 1'b0;
	end
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 64);
		if (n >= 64) stuck_o = 1'b1;
	endtask : wait_rdy
	// Write data is inverted after use so a stale bus value never looks valid.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		hsel_o <= 1'b1;
		htrans_o <= 2'h2;
		haddr_o <= a;
		hwrite_o <= w;
		wait_rdy();
		hsel_o <= 1'b0;
		htrans_o <= 2'h0;
		hwdata_o <= d;
		wait_rdy();
		q = hrdata_i;
		hwdata_o <= ~d;
	endtask : xfer
endmodule : brd_host
